// *** logic/xirq_pkg.sv ***
// constants and types shared by the extended interrupt enable and priority block
package xirq_pkg;
	localparam int XIRQ_SRC_N = 16;
	localparam int XIRQ_HI_N = 8;
	localparam logic [7:0] XIRQ_ADDR_EN_ONE = 8'he6;
	localparam logic [7:0] XIRQ_ADDR_EN_TWO = 8'he7;
	localparam logic [7:0] XIRQ_ADDR_PRIO_ONE = 8'hf6;
	localparam logic [3:0] XIRQ_PAGE_PRIO = 4'hf;
	localparam logic [7:0] XIRQ_RESET_VAL = 8'h00;
	localparam logic [7:0] XIRQ_EN_TWO_WMASK = 8'hfe;
	localparam logic [4:0] XIRQ_NONE = 5'h1f;
	// enable-one bit positions
	localparam int XIRQ_BIT_TIMER3 = 7;
	localparam int XIRQ_BIT_DMA_DONE = 6;
	localparam int XIRQ_BIT_DMA_MID = 5;
	localparam int XIRQ_BIT_COUNTER = 4;
	localparam int XIRQ_BIT_ADC_DONE = 3;
	localparam int XIRQ_BIT_ADC_WIN = 2;
	localparam int XIRQ_BIT_RTC_ALARM = 1;
	localparam int XIRQ_BIT_TWOWIRE = 0;
	// enable-two bit positions
	localparam int XIRQ_BIT_I2C_SLAVE = 7;
	localparam int XIRQ_BIT_CS_SCAN_END = 6;
	localparam int XIRQ_BIT_CS_COMPARE = 5;
	localparam int XIRQ_BIT_CS_DONE = 4;
	localparam int XIRQ_BIT_MAC = 3;
	localparam int XIRQ_BIT_RTC_OSC = 2;
	localparam int XIRQ_BIT_PORT_MATCH = 1;
	localparam int XIRQ_BIT_RSVD = 0;
	typedef enum logic [1:0] {
		XIRQ_LVL_NONE = 2'b00,
		XIRQ_LVL_LOW = 2'b01,
		XIRQ_LVL_HIGH = 2'b10
	} xirq_level_t;
endpackage

// *** logic/xirq_req_if.sv ***
// gated request vector and priority levels passed from gate to arbiter
`timescale 1ns/1ns
interface xirq_req_if;
	logic [xirq_pkg::XIRQ_SRC_N-1:0] gated;
	logic [xirq_pkg::XIRQ_SRC_N-1:0] high;
	modport gate (output gated, output high);
	modport arb (input gated, input high);
endinterface

// *** logic/xirq_gate.sv ***
// per-source masking of raw flags and priority level assignment
`timescale 1ns/1ns
module xirq_gate (
	input wire logic [xirq_pkg::XIRQ_SRC_N-1:0] src_flag,
	input wire logic [7:0] en_one,
	input wire logic [7:0] en_two,
	input wire logic [7:0] prio_one,
	input wire logic global_irq_enable,
	xirq_req_if.gate req
);
	logic [xirq_pkg::XIRQ_SRC_N-1:0] en_all;
	// sources 0..7 are enable-one bits 7..0, sources 8..15 enable-two bits 7..0
	assign en_all = {en_two[0], en_two[1], en_two[2], en_two[3], en_two[4], en_two[5],
		en_two[6], en_two[7], en_one[0], en_one[1], en_one[2], en_one[3], en_one[4],
		en_one[5], en_one[6], en_one[7]};
	genvar i;
	generate
		for (i = 0; i < xirq_pkg::XIRQ_SRC_N; i++) begin : g_src
			// masking only hides the flag, never clears it
			assign req.gated[i] = src_flag[i] & en_all[i] & global_irq_enable;
			if (i < xirq_pkg::XIRQ_HI_N) begin : g_prio
				assign req.high[i] = prio_one[xirq_pkg::XIRQ_HI_N-1-i];
			end else begin : g_low
				// second priority register is outside this block
				assign req.high[i] = 1'b0;
			end
		end
	endgenerate
endmodule // xirq_gate

// *** logic/xirq_top.sv ***
// extended interrupt enable and priority registers with request arbitration
`timescale 1ns/1ns
module xirq_top (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [7:0] sfr_addr,
	input wire logic [3:0] sfr_page,
	input wire logic sfr_wr,
	input wire logic [7:0] sfr_wdata,
	output logic [7:0] sfr_rdata,
	input wire logic global_irq_enable,
	input wire logic timer3_low_overflow_flag,
	input wire logic timer3_high_overflow_flag,
	input wire logic dma_done_flag,
	input wire logic dma_midpoint_flag,
	input wire logic counter_array_flag,
	input wire logic adc_done_flag,
	input wire logic adc_window_flag,
	input wire logic rtc_alarm_flag,
	input wire logic twowire_flag,
	input wire logic i2c_slave_flag,
	input wire logic capsense_scan_end_flag,
	input wire logic capsense_compare_flag,
	input wire logic capsense_done_flag,
	input wire logic mac_unit_flag,
	input wire logic rtc_osc_fail_flag,
	input wire logic port_match_flag,
	input wire logic core_in_low_isr,
	input wire logic core_in_high_isr,
	output logic irq_req,
	output logic irq_high,
	output logic [4:0] irq_source,
	output logic [7:0] timer3_irq_enable_out,
	output logic [15:0] irq_gated
);
	logic [7:0] en_one_q;
	logic [7:0] en_two_q;
	logic [7:0] prio_one_q;
	logic [7:0] rdata_d;
	logic [xirq_pkg::XIRQ_SRC_N-1:0] flags;
	logic hit_en_one;
	logic hit_en_two;
	logic hit_prio_one;
	logic [4:0] src_d;
	xirq_pkg::xirq_level_t lvl_d;
	xirq_req_if req ();

	assign hit_en_one = (sfr_addr == xirq_pkg::XIRQ_ADDR_EN_ONE);
	assign hit_en_two = (sfr_addr == xirq_pkg::XIRQ_ADDR_EN_TWO);
	assign hit_prio_one = (sfr_addr == xirq_pkg::XIRQ_ADDR_PRIO_ONE)
		&& (sfr_page == xirq_pkg::XIRQ_PAGE_PRIO);

	// source index order: enable-one bit 7 down to bit 0 first, then enable-two bit 7 down to bit 0
	// slot 15 sits under the reserved enable bit, so it is tied low
	assign flags = {1'b0, port_match_flag, rtc_osc_fail_flag, mac_unit_flag, capsense_done_flag,
		capsense_compare_flag, capsense_scan_end_flag, i2c_slave_flag,
		twowire_flag, rtc_alarm_flag, adc_window_flag, adc_done_flag, counter_array_flag,
		dma_midpoint_flag, dma_done_flag,
		timer3_low_overflow_flag | timer3_high_overflow_flag};

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			en_one_q <= xirq_pkg::XIRQ_RESET_VAL;
		end else if (sfr_wr && hit_en_one) begin
			en_one_q <= sfr_wdata;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			en_two_q <= xirq_pkg::XIRQ_RESET_VAL;
		end else if (sfr_wr && hit_en_two) begin
			// reserved bit held at reset value whatever software writes
			en_two_q <= sfr_wdata & xirq_pkg::XIRQ_EN_TWO_WMASK;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			prio_one_q <= xirq_pkg::XIRQ_RESET_VAL;
		end else if (sfr_wr && hit_prio_one) begin
			prio_one_q <= sfr_wdata;
		end
	end

	always_comb begin
		rdata_d = xirq_pkg::XIRQ_RESET_VAL;
		if (hit_en_one) begin
			rdata_d = en_one_q;
		end else if (hit_en_two) begin
			rdata_d = en_two_q;
		end else if (hit_prio_one) begin
			rdata_d = prio_one_q;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			sfr_rdata <= xirq_pkg::XIRQ_RESET_VAL;
		end else begin
			sfr_rdata <= rdata_d;
		end
	end

	xirq_gate u_gate (
		.src_flag(flags),
		.en_one(en_one_q),
		.en_two(en_two_q),
		.prio_one(prio_one_q),
		.global_irq_enable(global_irq_enable),
		.req(req)
	);

	// lowest index wins within a level; high level scanned last so it overrides low
	always_comb begin
		src_d = xirq_pkg::XIRQ_NONE;
		lvl_d = xirq_pkg::XIRQ_LVL_NONE;
		for (int k = xirq_pkg::XIRQ_SRC_N - 1; k >= 0; k--) begin
			if (req.gated[k] && !req.high[k]) begin
				src_d = 5'(k);
				lvl_d = xirq_pkg::XIRQ_LVL_LOW;
			end
		end
		for (int k = xirq_pkg::XIRQ_SRC_N - 1; k >= 0; k--) begin
			if (req.gated[k] && req.high[k]) begin
				src_d = 5'(k);
				lvl_d = xirq_pkg::XIRQ_LVL_HIGH;
			end
		end
		// only high preempts low: in high service nothing; in low service only high
		if (core_in_high_isr || (core_in_low_isr && lvl_d != xirq_pkg::XIRQ_LVL_HIGH)) begin
			src_d = xirq_pkg::XIRQ_NONE;
			lvl_d = xirq_pkg::XIRQ_LVL_NONE;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			irq_req <= 1'b0;
			irq_high <= 1'b0;
			irq_source <= xirq_pkg::XIRQ_NONE;
		end else begin
			irq_req <= (lvl_d != xirq_pkg::XIRQ_LVL_NONE);
			irq_high <= (lvl_d == xirq_pkg::XIRQ_LVL_HIGH);
			irq_source <= src_d;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			irq_gated <= 16'h0000;
			timer3_irq_enable_out <= xirq_pkg::XIRQ_RESET_VAL;
		end else begin
			irq_gated <= req.gated;
			timer3_irq_enable_out <= en_one_q;
		end
	end

	// register access steps shared by the write and read-back properties
	sequence s_wr_en_one;
		sfr_wr && hit_en_one;
	endsequence
	sequence s_wr_en_two;
		sfr_wr && hit_en_two;
	endsequence
	sequence s_wr_prio_one;
		sfr_wr && hit_prio_one;
	endsequence
	sequence s_prio_off_page;
		(sfr_addr == xirq_pkg::XIRQ_ADDR_PRIO_ONE) && (sfr_page != xirq_pkg::XIRQ_PAGE_PRIO);
	endsequence

	AST_GLOBAL_OFF: assert property (@(posedge clk_sys) disable iff (rst)
		!global_irq_enable |=> irq_gated == 16'h0000)
		else $error("request passed with global enable off");
	AST_TIMER3: assert property (@(posedge clk_sys) disable iff (rst)
		(global_irq_enable && en_one_q[xirq_pkg::XIRQ_BIT_TIMER3] && timer3_high_overflow_flag)
		|=> irq_gated[xirq_pkg::XIRQ_HI_N-1-xirq_pkg::XIRQ_BIT_TIMER3])
		else $error("timer 3 request not passed");
	AST_MASKED: assert property (@(posedge clk_sys) disable iff (rst)
		!en_one_q[xirq_pkg::XIRQ_BIT_DMA_DONE] |=> !irq_gated[xirq_pkg::XIRQ_HI_N-1-xirq_pkg::XIRQ_BIT_DMA_DONE])
		else $error("masked dma request passed");
	AST_RSVD: assert property (@(posedge clk_sys) disable iff (rst)
		en_two_q[xirq_pkg::XIRQ_BIT_RSVD] == 1'b0)
		else $error("reserved bit set");
	AST_PRIO_PAGE: assert property (@(posedge clk_sys) disable iff (rst)
		(sfr_wr && sfr_page != xirq_pkg::XIRQ_PAGE_PRIO) |=> $stable(prio_one_q))
		else $error("priority written off page");
	AST_EN_WRITE: assert property (@(posedge clk_sys) disable iff (rst)
		s_wr_en_one |=> en_one_q == $past(sfr_wdata))
		else $error("enable-one write lost");
	AST_HIGH_FIRST: assert property (@(posedge clk_sys) disable iff (rst)
		(|(req.gated & req.high) && !core_in_high_isr) |=> irq_req && irq_high)
		else $error("high request not first");
	AST_NO_LOW_PREEMPT: assert property (@(posedge clk_sys) disable iff (rst)
		core_in_low_isr |=> (!irq_req || irq_high))
		else $error("low preempted low");
	AST_CAPS: assert property (@(posedge clk_sys) disable iff (rst)
		(global_irq_enable && en_two_q[xirq_pkg::XIRQ_BIT_CS_SCAN_END] && capsense_scan_end_flag)
		|=> irq_gated[xirq_pkg::XIRQ_SRC_N-1-xirq_pkg::XIRQ_BIT_CS_SCAN_END])
		else $error("scan end not passed");

	AST_EN_TWO_WRITE: assert property (@(posedge clk_sys) disable iff (rst)
		s_wr_en_two
		|=> en_two_q == ($past(sfr_wdata) & xirq_pkg::XIRQ_EN_TWO_WMASK))
		else $error("enable-two write lost");
	AST_PRIO_WRITE: assert property (@(posedge clk_sys) disable iff (rst)
		s_wr_prio_one
		|=> prio_one_q == $past(sfr_wdata))
		else $error("priority write on its page lost");
	AST_PRIO_HIDDEN: assert property (@(posedge clk_sys) disable iff (rst)
		s_prio_off_page
		|=> sfr_rdata == xirq_pkg::XIRQ_RESET_VAL)
		else $error("priority register visible off its page");
	AST_RDATA_EN_ONE: assert property (@(posedge clk_sys) disable iff (rst)
		hit_en_one
		|=> sfr_rdata == $past(en_one_q))
		else $error("enable-one read-back wrong");

	AST_TIMER3_LOW: assert property (@(posedge clk_sys) disable iff (rst)
		(global_irq_enable && en_one_q[xirq_pkg::XIRQ_BIT_TIMER3] && timer3_low_overflow_flag)
		|=> irq_gated[xirq_pkg::XIRQ_HI_N-1-xirq_pkg::XIRQ_BIT_TIMER3])
		else $error("timer 3 low overflow request not passed");
	AST_TIMER3_MASK: assert property (@(posedge clk_sys) disable iff (rst)
		!en_one_q[xirq_pkg::XIRQ_BIT_TIMER3]
		|=> !irq_gated[xirq_pkg::XIRQ_HI_N-1-xirq_pkg::XIRQ_BIT_TIMER3])
		else $error("masked timer 3 request passed");
	AST_DMA_DONE: assert property (@(posedge clk_sys) disable iff (rst)
		(global_irq_enable && en_one_q[xirq_pkg::XIRQ_BIT_DMA_DONE] && dma_done_flag)
		|=> irq_gated[xirq_pkg::XIRQ_HI_N-1-xirq_pkg::XIRQ_BIT_DMA_DONE])
		else $error("dma done request not passed");
	AST_DMA_MID: assert property (@(posedge clk_sys) disable iff (rst)
		(global_irq_enable && en_one_q[xirq_pkg::XIRQ_BIT_DMA_MID] && dma_midpoint_flag)
		|=> irq_gated[xirq_pkg::XIRQ_HI_N-1-xirq_pkg::XIRQ_BIT_DMA_MID])
		else $error("dma mid-point request not passed");
	AST_COUNTER: assert property (@(posedge clk_sys) disable iff (rst)
		(global_irq_enable && en_one_q[xirq_pkg::XIRQ_BIT_COUNTER] && counter_array_flag)
		|=> irq_gated[xirq_pkg::XIRQ_HI_N-1-xirq_pkg::XIRQ_BIT_COUNTER])
		else $error("counter array request not passed");
	AST_ADC_DONE: assert property (@(posedge clk_sys) disable iff (rst)
		(global_irq_enable && en_one_q[xirq_pkg::XIRQ_BIT_ADC_DONE] && adc_done_flag)
		|=> irq_gated[xirq_pkg::XIRQ_HI_N-1-xirq_pkg::XIRQ_BIT_ADC_DONE])
		else $error("adc done request not passed");
	AST_ADC_WIN: assert property (@(posedge clk_sys) disable iff (rst)
		(global_irq_enable && en_one_q[xirq_pkg::XIRQ_BIT_ADC_WIN] && adc_window_flag)
		|=> irq_gated[xirq_pkg::XIRQ_HI_N-1-xirq_pkg::XIRQ_BIT_ADC_WIN])
		else $error("adc window request not passed");
	AST_RTC_ALARM: assert property (@(posedge clk_sys) disable iff (rst)
		(global_irq_enable && en_one_q[xirq_pkg::XIRQ_BIT_RTC_ALARM] && rtc_alarm_flag)
		|=> irq_gated[xirq_pkg::XIRQ_HI_N-1-xirq_pkg::XIRQ_BIT_RTC_ALARM])
		else $error("rtc alarm request not passed");
	AST_TWOWIRE: assert property (@(posedge clk_sys) disable iff (rst)
		(global_irq_enable && en_one_q[xirq_pkg::XIRQ_BIT_TWOWIRE] && twowire_flag)
		|=> irq_gated[xirq_pkg::XIRQ_HI_N-1-xirq_pkg::XIRQ_BIT_TWOWIRE])
		else $error("two-wire request not passed");
	AST_I2C: assert property (@(posedge clk_sys) disable iff (rst)
		(global_irq_enable && en_two_q[xirq_pkg::XIRQ_BIT_I2C_SLAVE] && i2c_slave_flag)
		|=> irq_gated[xirq_pkg::XIRQ_SRC_N-1-xirq_pkg::XIRQ_BIT_I2C_SLAVE])
		else $error("i2c slave request not passed");
	AST_CS_COMPARE: assert property (@(posedge clk_sys) disable iff (rst)
		(global_irq_enable && en_two_q[xirq_pkg::XIRQ_BIT_CS_COMPARE] && capsense_compare_flag)
		|=> irq_gated[xirq_pkg::XIRQ_SRC_N-1-xirq_pkg::XIRQ_BIT_CS_COMPARE])
		else $error("capsense compare request not passed");
	AST_HIGH_SERVICE: assert property (@(posedge clk_sys) disable iff (rst)
		core_in_high_isr
		|=> !irq_req)
		else $error("request presented during high service");

	// a lone request is presented at the level its priority bit selects
	for (genvar p = 0; p < xirq_pkg::XIRQ_HI_N; p++) begin : g_prio_chk
		AST_PRIO_LEVEL: assert property (
			@(posedge clk_sys) disable iff (rst)
			$onehot(req.gated) && req.gated[p] && !core_in_high_isr
			&& (prio_one_q[xirq_pkg::XIRQ_HI_N-1-p] || !core_in_low_isr)
			|=> irq_req && (irq_high == $past(prio_one_q[xirq_pkg::XIRQ_HI_N-1-p]))
			&& (irq_source == 5'(p)))
			else $error("priority bit did not select the level");
	end
endmodule // xirq_top

// *** dv/xirq_core_model.sv ***
// core model: accepts presented requests and services each level for a few cycles
`timescale 1ns/1ns
module xirq_core_model (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic irq_req,
	input wire logic irq_high,
	output logic core_in_low_isr,
	output logic core_in_high_isr
);
	logic [2:0] svc_q;
	// short services so that nesting and returns happen often in a short run
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			core_in_low_isr <= 1'b0;
			core_in_high_isr <= 1'b0;
			svc_q <= 3'h0;
		end else if (irq_req && !core_in_high_isr && (irq_high || !core_in_low_isr)) begin
			if (irq_high) core_in_high_isr <= 1'b1;
			else core_in_low_isr <= 1'b1;
			svc_q <= 3'h5;
		end else if (svc_q != 3'h0) begin
			svc_q <= svc_q - 3'h1;
		end else if (core_in_high_isr) begin
			core_in_high_isr <= 1'b0;
		end else begin
			core_in_low_isr <= 1'b0;
		end
	end
endmodule // xirq_core_model

// *** dv/xirq_top_tb.sv ***
// self-checking random bench for the extended interrupt enable and priority block
`timescale 1ns/1ns
module xirq_top_tb;
	logic clk_sys = 1'b0, rst = 1'b1, sfr_wr = 1'b0, global_irq_enable = 1'b0;
	logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, en1 = 8'h00, en2 = 8'h00, pr1 = 8'h00;
	logic [3:0] sfr_page = 4'h0;
	logic [15:0] flg = 16'h0000, irq_gated;
	logic [7:0] sfr_rdata, timer3_irq_enable_out;
	logic irq_req, irq_high, core_in_low_isr, core_in_high_isr;
	logic [4:0] irq_source;
	logic [38:0] exp_q[$];
	logic [38:0] got_v, exp_v;
	int err_total = 0, total_checks = 0;

	xirq_top u_dut (.clk_sys, .rst, .sfr_addr, .sfr_page, .sfr_wr, .sfr_wdata, .sfr_rdata,
		.global_irq_enable, .timer3_low_overflow_flag(flg[15]), .timer3_high_overflow_flag(flg[0]),
		.dma_done_flag(flg[1]), .dma_midpoint_flag(flg[2]), .counter_array_flag(flg[3]),
		.adc_done_flag(flg[4]), .adc_window_flag(flg[5]), .rtc_alarm_flag(flg[6]),
		.twowire_flag(flg[7]), .i2c_slave_flag(flg[8]), .capsense_scan_end_flag(flg[9]),
		.capsense_compare_flag(flg[10]), .capsense_done_flag(flg[11]), .mac_unit_flag(flg[12]),
		.rtc_osc_fail_flag(flg[13]), .port_match_flag(flg[14]), .core_in_low_isr,
		.core_in_high_isr, .irq_req, .irq_high, .irq_source, .timer3_irq_enable_out, .irq_gated);
	xirq_core_model u_core (.clk_sys, .rst, .irq_req, .irq_high, .core_in_low_isr,
		.core_in_high_isr);

	initial forever #4 clk_sys = ~clk_sys;

	// expected outputs one edge after the current inputs; flg[15] doubles as timer 3 low
	function automatic logic [38:0] model();
		logic [15:0] g, h;
		logic [7:0] rd;
		logic [4:0] s;
		logic sh, e;
		s = 5'h1f;
		sh = 1'b0;
		for (int i = 15; i >= 0; i--) begin
			e = (i < 8) ? en1[7-i] : en2[15-i];
			g[i] = global_irq_enable & e & ((i == 0) ? (flg[0] | flg[15]) : flg[i]);
			h[i] = (i < 8) && pr1[7-i];
			if (g[i] && !core_in_high_isr && (h[i] || !core_in_low_isr) && (h[i] || !sh)) begin
				s = 5'(i);
				sh = h[i];
			end
		end
		rd = (sfr_addr == xirq_pkg::XIRQ_ADDR_EN_ONE) ? en1 :
			(sfr_addr == xirq_pkg::XIRQ_ADDR_EN_TWO) ? en2 :
			(sfr_addr == xirq_pkg::XIRQ_ADDR_PRIO_ONE && sfr_page == xirq_pkg::XIRQ_PAGE_PRIO) ?
			pr1 : 8'h00;
		return {rd, s != 5'h1f, sh, s, g, en1};
	endfunction

	task automatic step(input logic w);
		@(negedge clk_sys);
		case ($urandom % 4)
			0: sfr_addr = xirq_pkg::XIRQ_ADDR_EN_ONE;
			1: sfr_addr = xirq_pkg::XIRQ_ADDR_EN_TWO;
			2: sfr_addr = xirq_pkg::XIRQ_ADDR_PRIO_ONE;
			default: sfr_addr = 8'($urandom);
		endcase
		sfr_page = ($urandom % 2) ? xirq_pkg::XIRQ_PAGE_PRIO : 4'($urandom);
		sfr_wdata = 8'($urandom);
		if (sfr_addr == xirq_pkg::XIRQ_ADDR_EN_TWO) sfr_wdata[0] = 1'b0;
		flg = 16'($urandom);
		global_irq_enable = ($urandom % 4) != 0;
		sfr_wr = w;
		if (!w) exp_q.push_back(model());
		else if (sfr_addr == xirq_pkg::XIRQ_ADDR_EN_ONE) en1 = sfr_wdata;
		else if (sfr_addr == xirq_pkg::XIRQ_ADDR_EN_TWO) en2 = sfr_wdata;
		else if (sfr_addr == xirq_pkg::XIRQ_ADDR_PRIO_ONE && sfr_page == xirq_pkg::XIRQ_PAGE_PRIO)
			pr1 = sfr_wdata;
	endtask

	task automatic conclude();
		if (err_total == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic compare_field(input logic [15:0] exp_f, input logic [15:0] got_f);
		total_checks++;
		if (got_f !== exp_f) begin
			err_total++;
			$display("mismatch t=%0t exp=%h got=%h", $time, exp_f, got_f);
		end
	endtask

	// fields: read data, request and level, source, gated sources 0..3, 4..7, 8..15, enable copy
	always @(posedge clk_sys) begin
		#1;
		if (exp_q.size() > 0) begin
			got_v = {sfr_rdata, irq_req, irq_high, irq_source, irq_gated, timer3_irq_enable_out};
			exp_v = exp_q.pop_front();
			compare_field(16'(exp_v[38:31]), 16'(got_v[38:31]));
			compare_field(16'(exp_v[30:29]), 16'(got_v[30:29]));
			compare_field(16'(exp_v[28:24]), 16'(got_v[28:24]));
			compare_field(16'(exp_v[11:8]), 16'(got_v[11:8]));
			compare_field(16'(exp_v[15:12]), 16'(got_v[15:12]));
			compare_field(16'(exp_v[23:16]), 16'(got_v[23:16]));
			compare_field(16'(exp_v[7:0]), 16'(got_v[7:0]));
		end
	end

	initial begin
		void'($urandom(97));
		repeat (12) @(negedge clk_sys);
		rst = 1'b0;
		step(1'b0);
		repeat (1500) step(($urandom % 3) == 0);
		// reset again in mid-run: registers and core state must come back clean
		@(negedge clk_sys);
		sfr_wr = 1'b0;
		rst = 1'b1;
		en1 = 8'h00;
		en2 = 8'h00;
		pr1 = 8'h00;
		repeat (2) @(negedge clk_sys);
		rst = 1'b0;
		step(1'b0);
		repeat (300) step(($urandom % 3) == 0);
		repeat (2) @(negedge clk_sys);
		conclude();
	end

	// about 1800 cycles expected; a hang is cut off well beyond that
	initial begin
		#40000;
		err_total++;
		conclude();
	end
endmodule // xirq_top_tb
